// [src/wr_rx.sv]
// Receive write data state of a serial SCSI target transport layer
`timescale 1ns/1ps
// Functional notes
// [R1] On entry, load received byte counter with requested write offset.
// [R2] Retries off: frame offset unequal to counter is a data offset error.
// [R3] Offset below requested offset or at/above offset plus length: error.
// [R4] Byte count plus counter above request byte count: too much data.
// [R5] Frame with zero data bytes: information unit too short.
// [R6] One error reported; offset over too-much over too-short.
// [R7] Retries on, pointer clear, offset mismatch: discard until pointer set.
// [R8] Resume processing on arrival with changing pointer set.
// [R9] Verified frame adds byte count to counter and goes to buffer.
// [R10] Verified frame with pointer set reloads counter, still delivers data.
// [R11] Restart response timer on entry and on each processed frame.
// [R12] Stop the response timer before leaving the state.
// [R13] Timer expiry reports initiator response timeout.
// [R14] Counter equals request count and all ACKs in: report received.
// [R15] Cancel reports data transfer terminated.
// [R16] Every completion carries the command tag.
// [R17] After any completion, return to the start state.
// [R18] Counter below count, equals offset plus length, ACKs in: XFER_RDY.
// [R19] Before that, length = count minus old offset; offset = counter.
// [R20] Failed or discarded frames leave counter and buffer untouched.
// [R21] Count outstanding ACK confirmations; transitions wait for zero. Only received and XFER_RDY wait here; cancel, error and timeout exits do not.
module wr_rx #(
  parameter int IRT_COUNT = wr_rx_pkg::IRT_CYCLES
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_enter,
  input  wire logic                        i_retries_en,
  input  wire logic                        i_timer_en,
  input  wire logic [wr_rx_pkg::TAG_W-1:0] i_tag,
  input  wire logic [wr_rx_pkg::CNT_W-1:0] i_req_count,
  input  wire logic [wr_rx_pkg::CNT_W-1:0] i_req_offset,
  input  wire logic [wr_rx_pkg::CNT_W-1:0] i_req_length,
  input  wire logic                        i_frame_valid,
  input  wire logic [wr_rx_pkg::CNT_W-1:0] i_frame_offset,
  input  wire logic [wr_rx_pkg::CNT_W-1:0] i_frame_bytes,
  input  wire logic                        i_frame_cdp,
  input  wire logic                        i_ack_tx,
  input  wire logic                        i_cancel,
  output logic                             o_busy,
  output logic                             o_buf_we,
  output logic [wr_rx_pkg::CNT_W-1:0]      o_buf_offset,
  output logic [wr_rx_pkg::CNT_W-1:0]      o_buf_bytes,
  output logic                             o_done,
  output wr_rx_pkg::done_type              o_done_code,
  output logic [wr_rx_pkg::TAG_W-1:0]      o_done_tag,
  output logic                             o_xfer_rdy,
  output logic [wr_rx_pkg::CNT_W-1:0]      o_new_offset,
  output logic [wr_rx_pkg::CNT_W-1:0]      o_new_length,
  output logic [wr_rx_pkg::CNT_W-1:0]      o_received,
  output logic                             o_discarding
);

  localparam logic [wr_rx_pkg::TMR_W-1:0] IRT_LOAD =
    wr_rx_pkg::TMR_W'(IRT_COUNT);

  wr_rx_pkg::state_type               state;
  logic [wr_rx_pkg::CNT_W-1:0]        rx_cnt;
  logic [wr_rx_pkg::CNT_W-1:0]        rq_off;
  logic [wr_rx_pkg::CNT_W-1:0]        rq_len;
  logic [wr_rx_pkg::ACK_W-1:0]        ack_pend;
  logic [wr_rx_pkg::TMR_W-1:0]        timer;
  logic                               tmr_run;
  logic                               discard;

  // Frame check, evaluated combinationally on the arriving frame
  logic                               active;
  logic                               off_err;
  logic                               much_err;
  logic                               short_err;
  logic                               mismatch;
  logic                               skip;
  logic                               take;
  logic                               accept;
  logic                               acks_done;
  logic                               tmo;
  logic [wr_rx_pkg::CNT_W:0]          sum_wide;
  wr_rx_pkg::done_type                next_code;

  always_comb begin
    active    = (state == wr_rx_pkg::ST_RECEIVE);
    mismatch  = (i_frame_offset != rx_cnt);
    // Wide sum so a huge byte count cannot wrap past the limit
    sum_wide  = {1'b0, i_frame_bytes} + {1'b0, rx_cnt};
    off_err   = (!i_retries_en && mismatch) ||                    // [R2]
                (i_frame_offset < rq_off) ||                      // [R3]
                ({1'b0, i_frame_offset} >=
                 ({1'b0, rq_off} + {1'b0, rq_len}));              // [R3]
    much_err  = (sum_wide > {1'b0, i_req_count});                 // [R4]
    short_err = (i_frame_bytes == wr_rx_pkg::CNT_ZERO);           // [R5]
    // With retries on, the misplaced frame itself is dropped, not checked
    skip      = i_retries_en && !i_frame_cdp && mismatch;        // [R7]
    // Discard mode ends on the first arrival with the pointer set
    take      = active && i_frame_valid && !skip &&
                (!discard || i_frame_cdp);                        // [R8]
    accept    = take && !off_err && !much_err && !short_err;
    acks_done = (ack_pend == wr_rx_pkg::ACK_ZERO);                // [R21]
    tmo       = tmr_run && (timer == wr_rx_pkg::TMR_ONE);
  end

  // Completion priority: cancel, frame errors, timeout, then done
  always_comb begin
    next_code = wr_rx_pkg::DONE_NONE;
    if (active) begin
      if (i_cancel) begin
        next_code = wr_rx_pkg::DONE_TERMINATED;                   // [R15]
      end else if (take && off_err) begin
        next_code = wr_rx_pkg::DONE_OFFSET_ERR;                   // [R6]
      end else if (take && much_err) begin
        next_code = wr_rx_pkg::DONE_TOO_MUCH;                     // [R6]
      end else if (take && short_err) begin
        next_code = wr_rx_pkg::DONE_IU_SHORT;                     // [R6]
      end else if (tmo && !accept) begin
        next_code = wr_rx_pkg::DONE_TIMEOUT;                      // [R13]
      end else if (!i_frame_valid && acks_done &&
                   rx_cnt == i_req_count) begin
        next_code = wr_rx_pkg::DONE_RECEIVED;                     // [R14]
      end
    end
  end

  logic go_xfer;
  always_comb begin
    go_xfer = active && (next_code == wr_rx_pkg::DONE_NONE) &&
              !i_frame_valid && acks_done && (rx_cnt < i_req_count) &&
              ({1'b0, rx_cnt} == ({1'b0, rq_off} + {1'b0, rq_len})); // [R18]
  end

  // State sequencing; one ST_DRAIN cycle after leaving lets tail ACKs settle
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= wr_rx_pkg::ST_IDLE;
    end else begin
      case (state)
        wr_rx_pkg::ST_IDLE: begin
          if (i_enter) begin
            state <= wr_rx_pkg::ST_RECEIVE;
          end
        end
        wr_rx_pkg::ST_RECEIVE: begin
          if (next_code != wr_rx_pkg::DONE_NONE || go_xfer) begin
            state <= wr_rx_pkg::ST_DRAIN;                         // [R17]
          end
        end
        wr_rx_pkg::ST_DRAIN: begin
          state <= wr_rx_pkg::ST_IDLE;
        end
        default: begin
          state <= wr_rx_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Received byte counter and requested window
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rx_cnt <= wr_rx_pkg::CNT_ZERO;
      rq_off <= wr_rx_pkg::CNT_ZERO;
      rq_len <= wr_rx_pkg::CNT_ZERO;
    end else if (state == wr_rx_pkg::ST_IDLE && i_enter) begin
      rx_cnt <= i_req_offset;                                     // [R1]
      rq_off <= i_req_offset;
      rq_len <= i_req_length;
    end else if (accept && next_code == wr_rx_pkg::DONE_NONE) begin
      // Failed or discarded frames never reach here
      if (i_frame_cdp) begin
        rx_cnt <= rq_off;                                         // [R10]
      end else begin
        rx_cnt <= sum_wide[wr_rx_pkg::CNT_W-1:0];                 // [R9] [R20]
      end
    end
  end

  // Discard mode after an out of order frame with retries on
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      discard <= 1'b0;
    end else if (state == wr_rx_pkg::ST_IDLE) begin
      discard <= 1'b0;
    end else if (active && i_frame_valid) begin
      if (i_frame_cdp) begin
        discard <= 1'b0;                                          // [R8]
      end else if (i_retries_en && mismatch) begin
        discard <= 1'b1;                                          // [R7]
      end
    end
  end

  // Outstanding ACK confirmations; arrival and ACK in one cycle cancel
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ack_pend <= wr_rx_pkg::ACK_ZERO;
    end else if (state == wr_rx_pkg::ST_IDLE && i_enter) begin
      ack_pend <= wr_rx_pkg::ACK_ZERO;
    end else if (active) begin
      if (i_frame_valid && !(i_ack_tx && !acks_done)) begin
        ack_pend <= ack_pend + wr_rx_pkg::ACK_ONE;                // [R21]
      end else if (!i_frame_valid && i_ack_tx && !acks_done) begin
        ack_pend <= ack_pend - wr_rx_pkg::ACK_ONE;                // [R21]
      end
    end
  end

  // Response timer: load on entry and per processed frame
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      timer   <= wr_rx_pkg::TMR_ZERO;
      tmr_run <= 1'b0;
    end else if (state == wr_rx_pkg::ST_IDLE && i_enter && i_timer_en) begin
      timer   <= IRT_LOAD;                                        // [R11]
      tmr_run <= 1'b1;
    end else if (!active || next_code != wr_rx_pkg::DONE_NONE ||
                 go_xfer) begin
      timer   <= wr_rx_pkg::TMR_ZERO;                             // [R12]
      tmr_run <= 1'b0;
    end else if (tmr_run && accept) begin
      timer   <= IRT_LOAD;                                        // [R11]
    end else if (tmr_run) begin
      timer   <= timer - wr_rx_pkg::TMR_ONE;
    end
  end

  // Registered outputs to buffer and transfer control
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_buf_we     <= 1'b0;
      o_buf_offset <= wr_rx_pkg::CNT_ZERO;
      o_buf_bytes  <= wr_rx_pkg::CNT_ZERO;
      o_done       <= 1'b0;
      o_done_code  <= wr_rx_pkg::DONE_NONE;
      o_done_tag   <= '0;
      o_xfer_rdy   <= 1'b0;
      o_new_offset <= wr_rx_pkg::CNT_ZERO;
      o_new_length <= wr_rx_pkg::CNT_ZERO;
    end else begin
      o_buf_we     <= accept && next_code == wr_rx_pkg::DONE_NONE; // [R9]
      o_buf_offset <= i_frame_offset;
      o_buf_bytes  <= i_frame_bytes;
      o_done       <= next_code != wr_rx_pkg::DONE_NONE;
      o_done_code  <= next_code;
      o_done_tag   <= i_tag;                                      // [R16]
      o_xfer_rdy   <= go_xfer;
      if (go_xfer) begin
        o_new_length <= i_req_count - rq_off;                     // [R19]
        o_new_offset <= rx_cnt;                                   // [R19]
      end
    end
  end

  // Status mirrors
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_busy       <= 1'b0;
      o_received   <= wr_rx_pkg::CNT_ZERO;
      o_discarding <= 1'b0;
    end else begin
      o_busy       <= (state != wr_rx_pkg::ST_IDLE);
      o_received   <= rx_cnt;
      o_discarding <= discard;
    end
  end

  // Completion reporting and the way out of the state
  a_done_tag: assert property ( // [R16]
    @(posedge i_clk) disable iff (!i_rst_n)
    o_done |-> o_done_tag == $past(i_tag))
    else $error("completion tag mismatch");
  a_cancel_term: assert property ( // [R15]
    @(posedge i_clk) disable iff (!i_rst_n)
    (active && i_cancel) |=> (o_done &&
      o_done_code == wr_rx_pkg::DONE_TERMINATED))
    else $error("cancel not reported");
  a_leave_start: assert property ( // [R17]
    @(posedge i_clk) disable iff (!i_rst_n)
    o_done |=> state == wr_rx_pkg::ST_IDLE)
    else $error("no return to start");
  a_entry_load: assert property ( // [R1]
    @(posedge i_clk) disable iff (!i_rst_n)
    (state == wr_rx_pkg::ST_IDLE && i_enter) |=>
      rx_cnt == $past(i_req_offset))
    else $error("counter not loaded on entry");
  a_fail_hold: assert property ( // [R20]
    @(posedge i_clk) disable iff (!i_rst_n)
    (take && (off_err || much_err || short_err)) |=>
      (rx_cnt == $past(rx_cnt) && !o_buf_we))
    else $error("failed frame changed counter");
  a_offset_first: assert property ( // [R6]
    @(posedge i_clk) disable iff (!i_rst_n)
    (active && !i_cancel && take && off_err) |=>
      o_done_code == wr_rx_pkg::DONE_OFFSET_ERR)
    else $error("offset error lost priority");
  a_short_iu: assert property ( // [R5]
    @(posedge i_clk) disable iff (!i_rst_n)
    (active && !i_cancel && take && !off_err && !much_err && short_err)
      |=> o_done_code == wr_rx_pkg::DONE_IU_SHORT)
    else $error("short frame not reported");
  a_done_acks: assert property ( // [R14]
    @(posedge i_clk) disable iff (!i_rst_n)
    (o_done && o_done_code == wr_rx_pkg::DONE_RECEIVED) |->
      $past(ack_pend) == wr_rx_pkg::ACK_ZERO)
    else $error("done before all ACKs");
  a_timer_stop: assert property ( // [R12]
    @(posedge i_clk) disable iff (!i_rst_n)
    (state == wr_rx_pkg::ST_DRAIN) |-> !tmr_run)
    else $error("timer left running");
  a_xfer_len: assert property ( // [R19]
    @(posedge i_clk) disable iff (!i_rst_n)
    go_xfer |=> o_xfer_rdy &&
      o_new_length == $past(i_req_count) - $past(rq_off))
    else $error("new length wrong");

  // Discard, counter and timer behaviour
  a_discard_drop: assert property ( // [R7]
    @(posedge i_clk) disable iff (!i_rst_n)
    (active && i_frame_valid && !i_frame_cdp &&
      (discard || (i_retries_en && mismatch))) |=>
      (!o_buf_we && rx_cnt == $past(rx_cnt)))
    else $error("discarded frame was processed");
  a_ptr_reload: assert property ( // [R10]
    @(posedge i_clk) disable iff (!i_rst_n)
    (accept && i_frame_cdp && next_code == wr_rx_pkg::DONE_NONE) |=>
      (rx_cnt == rq_off && o_buf_we))
    else $error("pointer change did not reload counter");
  a_count_add: assert property ( // [R9]
    @(posedge i_clk) disable iff (!i_rst_n)
    (accept && !i_frame_cdp && next_code == wr_rx_pkg::DONE_NONE) |=>
      (rx_cnt == $past(rx_cnt) + $past(i_frame_bytes) && o_buf_we))
    else $error("counter not advanced by frame");
  a_much_next: assert property ( // [R4]
    @(posedge i_clk) disable iff (!i_rst_n)
    (active && !i_cancel && take && !off_err && much_err) |=>
      o_done_code == wr_rx_pkg::DONE_TOO_MUCH)
    else $error("too much data not reported");
  a_timeout_rep: assert property ( // [R13]
    @(posedge i_clk) disable iff (!i_rst_n)
    (active && tmo && !i_cancel && !take) |=>
      (o_done && o_done_code == wr_rx_pkg::DONE_TIMEOUT))
    else $error("timer expiry not reported");
  a_timer_load: assert property ( // [R11]
    @(posedge i_clk) disable iff (!i_rst_n)
    (state == wr_rx_pkg::ST_IDLE && i_enter && i_timer_en) |=>
      (tmr_run && timer == IRT_LOAD))
    else $error("timer not started on entry");
  a_xfer_acks: assert property ( // [R18] [R21]
    @(posedge i_clk) disable iff (!i_rst_n)
    o_xfer_rdy |-> $past(ack_pend) == wr_rx_pkg::ACK_ZERO)
    else $error("xfer ready before all ACKs");
  a_xfer_stop: assert property ( // [R12]
    @(posedge i_clk) disable iff (!i_rst_n)
    o_xfer_rdy |-> !tmr_run)
    else $error("timer running at xfer ready");

endmodule // wr_rx

// [shared/wr_rx_pkg.sv]
// Constants and types for the target write data receive block
package wr_rx_pkg;
  localparam int CNT_W = 32;              // Byte counts and offsets
  localparam int TAG_W = 16;              // Command tag width
  localparam int ACK_W = 8;               // Outstanding ACK counter width
  localparam int TMR_W = 32;              // Response timer width
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [ACK_W-1:0] ACK_ZERO = 8'h00;
  localparam logic [ACK_W-1:0] ACK_ONE  = 8'h01;
  localparam logic [TMR_W-1:0] TMR_ZERO = 32'h0000_0000;
  localparam logic [TMR_W-1:0] TMR_ONE  = 32'h0000_0001;
  // Initiator response timeout, in microseconds, and clock period in ns
  localparam int IRT_US = 1000;
  localparam int CLK_NS = 5;
  localparam int IRT_CYCLES = (IRT_US * 1000) / CLK_NS;

  // Completion codes reported to transfer control
  typedef enum logic [2:0] {
    DONE_NONE       = 3'b000,
    DONE_OFFSET_ERR = 3'b001,
    DONE_TOO_MUCH   = 3'b010,
    DONE_IU_SHORT   = 3'b011,
    DONE_TIMEOUT    = 3'b100,
    DONE_RECEIVED   = 3'b101,
    DONE_TERMINATED = 3'b110
  } done_type;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_RECEIVE = 2'b01,
    ST_DRAIN   = 2'b10
  } state_type;
endpackage

// [verif/init_model.sv]
// Behavioural initiator port: sends write data frames, returns ACKs
`timescale 1ns/1ps
module init_model (
  input  wire logic        i_clk,
  input  wire logic        i_go,
  input  wire logic        i_slow,
  input  wire logic [31:0] i_off,
  input  wire logic [31:0] i_bytes,
  input  wire logic        i_cdp,
  output logic             o_frame_valid,
  output logic [31:0]      o_frame_offset,
  output logic [31:0]      o_frame_bytes,
  output logic             o_frame_cdp,
  output logic             o_ack_tx
);
  logic [7:0] pend = 8'h00;
  initial begin
    o_frame_valid  = 1'b0;
    o_frame_offset = 32'h0000_0000;
    o_frame_bytes  = 32'h0000_0000;
    o_frame_cdp    = 1'b0;
  end
  // Fields are only good in the valid cycle; toggle them outside it
  // so a design that samples late never sees a stale frame
  always @(posedge i_clk) begin
    o_frame_valid <= i_go;
    if (i_go) begin
      o_frame_offset <= i_off;
      o_frame_bytes  <= i_bytes;
      o_frame_cdp    <= i_cdp;
    end else begin
      o_frame_offset <= ~o_frame_offset;
      o_frame_bytes  <= ~o_frame_bytes;
      o_frame_cdp    <= ~o_frame_cdp;
    end
  end
  // One ACK per frame, prompt or six cycles late
  always @(posedge i_clk) begin
    pend <= {1'b0, pend[7:1]} | (i_go ? (i_slow ? 8'h40 : 8'h02) : 8'h00);
  end
  assign o_ack_tx = pend[0];
endmodule // init_model

// [verif/wr_rx_tb.sv]
// Self-checking bench for the write data receive block
`timescale 1ns/1ps
module wr_rx_tb;
  localparam int IRT = 20;  // Short response timeout keeps runs brief
  logic clk = 1'b0, rst_n = 1'b0, enter = 1'b0, retries_en = 1'b0;
  logic timer_en = 1'b0, go = 1'b0, slow = 1'b0, m_cdp = 1'b0;
  logic cancel = 1'b0;
  logic [15:0] tag = 16'h0000;
  logic [31:0] req_count = 32'h0, req_offset = 32'h0, req_length = 32'h0;
  logic [31:0] m_off = 32'h0, m_bytes = 32'h0;
  logic frame_valid, frame_cdp, ack_tx, busy, buf_we, done, xfer_rdy;
  logic discarding;
  logic [31:0] frame_offset, frame_bytes, buf_offset, buf_bytes;
  logic [31:0] new_offset, new_length, received;
  logic [15:0] done_tag;
  wr_rx_pkg::done_type done_code;
  int fails = 0;
  int n_checks = 0;
  always #2.5 clk = ~clk;
  init_model i_model (.i_clk(clk), .i_go(go), .i_slow(slow),
    .i_off(m_off), .i_bytes(m_bytes), .i_cdp(m_cdp),
    .o_frame_valid(frame_valid), .o_frame_offset(frame_offset),
    .o_frame_bytes(frame_bytes), .o_frame_cdp(frame_cdp),
    .o_ack_tx(ack_tx));
  wr_rx #(.IRT_COUNT(IRT)) i_dut (.i_clk(clk), .i_rst_n(rst_n),
    .i_enter(enter), .i_retries_en(retries_en), .i_timer_en(timer_en),
    .i_tag(tag), .i_req_count(req_count), .i_req_offset(req_offset),
    .i_req_length(req_length), .i_frame_valid(frame_valid),
    .i_frame_offset(frame_offset), .i_frame_bytes(frame_bytes),
    .i_frame_cdp(frame_cdp), .i_ack_tx(ack_tx), .i_cancel(cancel),
    .o_busy(busy), .o_buf_we(buf_we), .o_buf_offset(buf_offset),
    .o_buf_bytes(buf_bytes), .o_done(done), .o_done_code(done_code),
    .o_done_tag(done_tag), .o_xfer_rdy(xfer_rdy),
    .o_new_offset(new_offset), .o_new_length(new_length),
    .o_received(received), .o_discarding(discarding));
  task automatic finish_test();
    if (fails == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // Idle gap first: the block needs a drain and an idle cycle
  task automatic start(input logic [31:0] off, len, cnt, input logic rt,
                       tm, input logic [15:0] tg);
    repeat (3) tick();
    req_offset = off;
    req_length = len;
    req_count = cnt;
    retries_en = rt;
    timer_en = tm;
    tag = tg;
    enter = 1'b1;
    tick();
    enter = 1'b0;
    tick();
    check("received", received, off);
  endtask
  // Returns in the cycle where the buffer write would stand
  task automatic send(input logic [31:0] off, bytes, input logic cdp);
    m_off = off;
    m_bytes = bytes;
    m_cdp = cdp;
    go = 1'b1;
    tick();
    go = 1'b0;
    tick();
  endtask
  task automatic wait_done(input wr_rx_pkg::done_type code);
    int i;
    i = 0;
    while (done !== 1'b1 && i < 40) begin
      tick();
      i++;
    end
    check("done", 32'(done), 32'h1);
    check("done_code", 32'(done_code), 32'(code));
    check("done_tag", 32'(done_tag), 32'(tag));
    repeat (3) tick();
    check("busy", 32'(busy), 32'h0);
  endtask
  task automatic t_basic();
    start(32'h0, 32'h8, 32'h8, 1'b0, 1'b0, 16'h00A5);
    send(32'h0, 32'h8, 1'b0);
    check("buf_we", 32'(buf_we), 32'h1);
    check("buf_offset", buf_offset, 32'h0);
    check("buf_bytes", buf_bytes, 32'h8);
    // Status mirrors trail the counter by one cycle
    tick();
    check("received", received, 32'h8);
    wait_done(wr_rx_pkg::DONE_RECEIVED);
  endtask
  // Frame checks against offset 16, length 16, count 32
  task automatic t_errors();
    logic [31:0] offs [4] = '{32'h8, 32'h10, 32'h10, 32'h14};
    logic [31:0] byts [4] = '{32'h0, 32'h14, 32'h0, 32'h4};
    wr_rx_pkg::done_type codes [4] = '{wr_rx_pkg::DONE_OFFSET_ERR,
      wr_rx_pkg::DONE_TOO_MUCH, wr_rx_pkg::DONE_IU_SHORT,
      wr_rx_pkg::DONE_OFFSET_ERR};
    for (int i = 0; i < 4; i++) begin
      start(32'h10, 32'h10, 32'h20, 1'b0, 1'b0, 16'h0B00 + 16'(i));
      send(offs[i], byts[i], 1'b0);
      check("buf_we", 32'(buf_we), 32'h0);
      check("received", received, 32'h10);
      wait_done(codes[i]);
    end
  endtask
  // Late ACK must hold back the move to XFER_RDY preparation
  task automatic t_xfer();
    int i;
    start(32'h0, 32'h8, 32'h10, 1'b0, 1'b0, 16'h0C3C);
    slow = 1'b1;
    send(32'h0, 32'h8, 1'b0);
    slow = 1'b0;
    for (i = 0; i < 3; i++) begin
      check("xfer_rdy", 32'(xfer_rdy | done), 32'h0);
      tick();
    end
    i = 0;
    while (xfer_rdy !== 1'b1 && i < 12) begin
      tick();
      i++;
    end
    check("xfer_rdy", 32'(xfer_rdy), 32'h1);
    check("new_length", new_length, 32'h10);
    check("new_offset", new_offset, 32'h8);
    repeat (3) tick();
    check("busy", 32'(busy), 32'h0);
  endtask
  // Retries on: a misplaced frame opens discard until a pointer change;
  // counter is nonzero first so the reload to the offset is visible
  task automatic t_discard();
    start(32'h0, 32'h10, 32'h10, 1'b1, 1'b0, 16'h0D11);
    send(32'h0, 32'h4, 1'b0);
    tick();
    check("received", received, 32'h4);
    send(32'h8, 32'h4, 1'b0);
    check("buf_we", 32'(buf_we), 32'h0);
    tick();
    check("discarding", 32'(discarding), 32'h1);
    check("received", received, 32'h4);
    send(32'h4, 32'h4, 1'b0);
    check("buf_we", 32'(buf_we), 32'h0);
    tick();
    check("received", received, 32'h4);
    send(32'h0, 32'h8, 1'b1);
    check("buf_we", 32'(buf_we), 32'h1);
    tick();
    check("discarding", 32'(discarding), 32'h0);
    check("received", received, 32'h0);
    send(32'h0, 32'h8, 1'b0);
    tick();
    check("received", received, 32'h8);
    cancel = 1'b1;
    tick();
    cancel = 1'b0;
    wait_done(wr_rx_pkg::DONE_TERMINATED);
  endtask
  // Without a restart at the frame the timer would expire in the 12 checked cycles after it
  task automatic t_timer();
    start(32'h0, 32'h10, 32'h10, 1'b0, 1'b1, 16'h0E77);
    repeat (10) tick();
    send(32'h0, 32'h4, 1'b0);
    for (int i = 0; i < 12; i++) begin
      check("done", 32'(done), 32'h0);
      tick();
    end
    wait_done(wr_rx_pkg::DONE_TIMEOUT);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_basic();
    t_errors();
    t_xfer();
    t_discard();
    t_timer();
    finish_test();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #50000;
    fails++;
    finish_test();
  end
endmodule // wr_rx_tb
